// >>> rtl/ldpc_pkg.sv
package ldpc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] RX_POLL_OFS = 8'h10;
  localparam logic [7:0] RX_BASE_OFS = 8'h18;
  localparam logic [7:0] TX_BASE_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] NAC_OFS = 8'h30;

  localparam logic [31:0] RX_POLL_RST = 32'h0fff_ffff;
  localparam logic [31:0] NAC_RST = 32'h0008_0040;
  localparam logic [31:0] NAC_WR_MASK = 32'h0028_fcea;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] RING_ALIGN = 2'h0;

  // ****************************************
  // network access control fields
  // ****************************************
  localparam int NAC_WHOLE_FRAME = 21;
  localparam int NAC_SQE_OFF = 19;
  localparam int NAC_LEVEL_LO = 14;
  localparam int NAC_TX_RUN = 13;
  localparam int NAC_COLL = 12;
  localparam int NAC_LOOP_LO = 10;
  localparam int NAC_ALL_GROUP = 7;
  localparam int NAC_ANY_GOOD = 6;
  localparam int NAC_BACKOFF = 5;
  localparam int NAC_DAMAGED = 3;
  localparam int NAC_RX_RUN = 1;
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_MAC = 2'h1;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_TX_DONE = 0;
  localparam int ST_TX_STOP = 1;
  localparam int ST_TX_NODESC = 2;
  localparam int ST_JABBER = 3;
  localparam int ST_TX_UNDER = 5;
  localparam int ST_RX_DONE = 6;
  localparam int ST_RX_NODESC = 7;
  localparam int ST_RX_STOP = 8;
  localparam int ST_RX_WDOG = 9;
  localparam int ST_GP_TIMER = 11;
  localparam int ST_FATAL = 13;
  localparam int ST_FLAGS = 14;
  localparam logic [13:0] NORMAL_MASK = 14'h0045;
  localparam logic [13:0] ABNORMAL_MASK = 14'h2baa;

  localparam logic [2:0] FAULT_PARITY = 3'h0;
  localparam logic [2:0] FAULT_MASTER = 3'h1;
  localparam logic [2:0] FAULT_TARGET = 3'h2;

  // ****************************************
  // process state report codes
  // ****************************************
  localparam logic [2:0] TXC_STOP = 3'h0;
  localparam logic [2:0] TXC_FETCH = 3'h1;
  localparam logic [2:0] TXC_SEND = 3'h2;
  localparam logic [2:0] TXC_FILL = 3'h3;
  localparam logic [2:0] TXC_SUSP = 3'h6;
  localparam logic [2:0] TXC_WB = 3'h7;
  localparam logic [2:0] RXC_STOP = 3'h0;
  localparam logic [2:0] RXC_FETCH = 3'h1;
  localparam logic [2:0] RXC_CHECK = 3'h2;
  localparam logic [2:0] RXC_WAIT = 3'h3;
  localparam logic [2:0] RXC_SUSP = 3'h4;
  localparam logic [2:0] RXC_WB = 3'h5;
  localparam logic [2:0] RXC_FLUSH = 3'h6;
  localparam logic [2:0] RXC_DRAIN = 3'h7;

  // fifo start levels in bytes, indexed by the level code
  localparam logic [10:0] LVL_FAST [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
  localparam logic [10:0] LVL_SLOW [4] = '{11'h048, 11'h060, 11'h080, 11'h0a0};

  typedef enum logic [2:0] {
    TX_STOP, TX_FETCH, TX_FILL, TX_SEND, TX_WB, TX_SUSP
  } ldpc_tx_state_type;

  typedef enum logic [2:0] {
    RX_STOP, RX_FETCH, RX_WAIT, RX_DRAIN, RX_CHECK, RX_WB, RX_FLUSH, RX_SUSP
  } ldpc_rx_state_type;

  // ****************************************
  // carriers to and from the dma engine
  // ****************************************
  typedef struct packed {
    logic desc_done;
    logic desc_owned;
    logic desc_irq;
    logic fifo_has_frame;
    logic [10:0] fifo_level;
    logic frame_end;
    logic underflow;
    logic jabber;
    logic wr_done;
    logic poll;
  } ldpc_tx_evt_type;

  typedef struct packed {
    logic fetch;
    logic fill;
    logic send;
    logic wb;
    logic wb_underflow;
    logic wb_jabber;
    logic [10:0] start_level;
    logic force_coll;
    logic [1:0] loop_mode;
    logic backoff_hold;
    logic sqe_off;
    logic [31:0] ring_base;
  } ldpc_tx_cmd_type;

  typedef struct packed {
    logic desc_done;
    logic desc_owned;
    logic frame_start;
    logic frame_end;
    logic dest_match;
    logic multicast;
    logic bad;
    logic ctrl_frame;
    logic wr_done;
    logic flush_done;
    logic watchdog;
    logic gp_timer;
  } ldpc_rx_evt_type;

  typedef struct packed {
    logic fetch;
    logic drain;
    logic check;
    logic wb;
    logic flush;
    logic accept;
    logic [31:0] ring_base;
  } ldpc_rx_cmd_type;

  typedef struct packed {
    logic parity;
    logic master_abort;
    logic target_abort;
  } ldpc_fault_type;

endpackage

// >>> rtl/ldpc_sticky.sv
`timescale 1ns/1ps
module ldpc_sticky #(
  parameter int W = 14
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);

  // an event in the same cycle as its clear is kept
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule

// >>> rtl/ldpc_dma_ctrl.sv
`timescale 1ns/1ps
module ldpc_dma_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic speed_100,
  input wire logic sec_normal,
  input wire logic sec_abnormal,
  input wire ldpc_pkg::ldpc_tx_evt_type tx_evt,
  input wire ldpc_pkg::ldpc_rx_evt_type rx_evt,
  input wire ldpc_pkg::ldpc_fault_type fault,
  output ldpc_pkg::ldpc_tx_cmd_type tx_cmd,
  output ldpc_pkg::ldpc_rx_cmd_type rx_cmd,
  output logic bus_master_en
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    return (old & ~be_mask(be)) | (nw & be_mask(be));
  endfunction

  // ring bases keep only the upper thirty bits of the merged word
  function automatic logic [29:0] base_merge(input logic [29:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = be_merge({old, ldpc_pkg::RING_ALIGN}, nw, be);
    return m[31:2];
  endfunction

  function automatic logic [10:0] start_level(input logic [1:0] code, input logic fast);
    // code 11 is taken as the top level
    return fast ? ldpc_pkg::LVL_FAST[code] : ldpc_pkg::LVL_SLOW[code];
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic ack_q;
  logic wr_fire;
  logic [31:0] rd_q;
  logic [31:0] rd_mux;
  logic [31:0] poll_q;
  logic [29:0] rx_base_q;
  logic [29:0] tx_base_q;
  logic [31:0] nac_q;
  logic [2:0] fault_kind_q;
  logic halt_q;
  logic [13:0] flags;
  logic [13:0] flag_set;
  logic [13:0] flag_clr;
  logic [31:0] clr_word;
  logic normal_summary;
  logic abnormal_summary;
  logic [2:0] tx_code;
  logic [2:0] rx_code;
  logic tx_run;
  logic rx_run;
  logic rx_poll;
  logic any_fault;
  logic addr_ok;
  logic frame_ok;
  logic tx_go;
  logic tx_irq_q;
  logic uf_q;
  logic jab_q;
  logic tci_set;
  logic tdu_set;
  logic rci_set;
  logic rdu_set;
  ldpc_pkg::ldpc_tx_state_type tx_q;
  ldpc_pkg::ldpc_tx_state_type tx_d;
  ldpc_pkg::ldpc_rx_state_type rx_q;
  ldpc_pkg::ldpc_rx_state_type rx_d;

  // ****************************************
  // avalon slave: one wait cycle, then answer
  // ****************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign avs_readdata = rd_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_comb begin
    unique case (avs_address)
      ldpc_pkg::RX_POLL_OFS: rd_mux = poll_q;
      ldpc_pkg::RX_BASE_OFS: rd_mux = {rx_base_q, ldpc_pkg::RING_ALIGN};
      ldpc_pkg::TX_BASE_OFS: rd_mux = {tx_base_q, ldpc_pkg::RING_ALIGN};
      ldpc_pkg::STATUS_OFS: rd_mux = {6'h00, fault_kind_q, tx_code, rx_code,
                                     normal_summary, abnormal_summary, 1'b0, flags};
      ldpc_pkg::NAC_OFS: rd_mux = nac_q;
      default: rd_mux = ldpc_pkg::ZERO_WORD;
    endcase
  end

  // read data is caught while waitrequest is still high
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_q <= '0;
    end else if (avs_read & ~ack_q) begin
      rd_q <= rd_mux;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      poll_q <= ldpc_pkg::RX_POLL_RST;
    end else if (wr_fire && avs_address == ldpc_pkg::RX_POLL_OFS) begin
      poll_q <= be_merge(poll_q, avs_writedata, avs_byteenable);
    end
  end

  // any value written while suspended counts as a demand
  assign rx_poll = wr_fire && avs_address == ldpc_pkg::RX_POLL_OFS
                   && rx_q == ldpc_pkg::RX_SUSP;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_base_q <= '0;
    end else if (wr_fire && avs_address == ldpc_pkg::RX_BASE_OFS) begin
      rx_base_q <= base_merge(rx_base_q, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_base_q <= '0;
    end else if (wr_fire && avs_address == ldpc_pkg::TX_BASE_OFS) begin
      tx_base_q <= base_merge(tx_base_q, avs_writedata, avs_byteenable);
    end
  end

  // reserved bits are never stored, so they read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nac_q <= ldpc_pkg::NAC_RST;
    end else if (wr_fire && avs_address == ldpc_pkg::NAC_OFS) begin
      nac_q <= be_merge(nac_q, avs_writedata, avs_byteenable) & ldpc_pkg::NAC_WR_MASK;
    end
  end

  assign tx_run = nac_q[ldpc_pkg::NAC_TX_RUN];
  assign rx_run = nac_q[ldpc_pkg::NAC_RX_RUN];

  // ****************************************
  // bus fault capture
  // ****************************************
  assign any_fault = fault.parity | fault.master_abort | fault.target_abort;

  // the first fault is kept; mastering stays off until reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_kind_q <= ldpc_pkg::FAULT_PARITY;
      halt_q <= 1'b0;
    end else if (any_fault && !halt_q) begin
      halt_q <= 1'b1;
      if (fault.parity) begin
        fault_kind_q <= ldpc_pkg::FAULT_PARITY;
      end else if (fault.master_abort) begin
        fault_kind_q <= ldpc_pkg::FAULT_MASTER;
      end else begin
        fault_kind_q <= ldpc_pkg::FAULT_TARGET;
      end
    end
  end

  assign bus_master_en = ~halt_q;

  // ****************************************
  // transmit process
  // ****************************************
  assign tx_go = nac_q[ldpc_pkg::NAC_WHOLE_FRAME] ? tx_evt.fifo_has_frame
                 : tx_evt.fifo_level >= tx_cmd.start_level;

  always_comb begin
    tx_d = tx_q;
    tci_set = 1'b0;
    tdu_set = 1'b0;
    // a fault stops the engine at the very edge that records it
    if (halt_q || any_fault) begin
      tx_d = ldpc_pkg::TX_STOP;
    end else begin
      unique case (tx_q)
        ldpc_pkg::TX_STOP: if (tx_run) tx_d = ldpc_pkg::TX_FETCH;
        ldpc_pkg::TX_FETCH: if (tx_evt.desc_done) begin
          if (!tx_run) begin
            tx_d = ldpc_pkg::TX_STOP;
          end else if (tx_evt.desc_owned) begin
            tx_d = ldpc_pkg::TX_FILL;
          end else begin
            tx_d = ldpc_pkg::TX_SUSP;
            tdu_set = 1'b1;
          end
        end
        ldpc_pkg::TX_FILL: begin
          if (!tx_run) begin
            tx_d = ldpc_pkg::TX_STOP;
          end else if (tx_go) begin
            tx_d = ldpc_pkg::TX_SEND;
          end
        end
        ldpc_pkg::TX_SEND: begin
          if (tx_evt.underflow || tx_evt.jabber) begin
            tx_d = ldpc_pkg::TX_WB;
          end else if (tx_evt.frame_end) begin
            tx_d = ldpc_pkg::TX_WB;
            tci_set = tx_irq_q;
          end
        end
        ldpc_pkg::TX_WB: if (tx_evt.wr_done) begin
          if (jab_q || !tx_run) begin
            tx_d = ldpc_pkg::TX_STOP;
          end else if (uf_q) begin
            tx_d = ldpc_pkg::TX_SUSP;
          end else begin
            tx_d = ldpc_pkg::TX_FETCH;
          end
        end
        ldpc_pkg::TX_SUSP: begin
          if (!tx_run) begin
            tx_d = ldpc_pkg::TX_STOP;
          end else if (tx_evt.poll) begin
            tx_d = ldpc_pkg::TX_FETCH;
          end
        end
        default: tx_d = ldpc_pkg::TX_STOP;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_q <= ldpc_pkg::TX_STOP;
    end else begin
      tx_q <= tx_d;
    end
  end

  // descriptor error bits held until the write-back finishes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_irq_q <= 1'b0;
      uf_q <= 1'b0;
      jab_q <= 1'b0;
    end else begin
      if (tx_q == ldpc_pkg::TX_FETCH && tx_evt.desc_done) begin
        tx_irq_q <= tx_evt.desc_irq;
      end
      if (tx_q == ldpc_pkg::TX_SEND && tx_evt.underflow) begin
        uf_q <= 1'b1;
      end else if (tx_q == ldpc_pkg::TX_WB && tx_evt.wr_done) begin
        uf_q <= 1'b0;
      end
      if (tx_q == ldpc_pkg::TX_SEND && tx_evt.jabber) begin
        jab_q <= 1'b1;
      end else if (tx_q == ldpc_pkg::TX_WB && tx_evt.wr_done) begin
        jab_q <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (tx_q)
      ldpc_pkg::TX_STOP: tx_code = ldpc_pkg::TXC_STOP;
      ldpc_pkg::TX_FETCH: tx_code = ldpc_pkg::TXC_FETCH;
      ldpc_pkg::TX_FILL: tx_code = ldpc_pkg::TXC_FILL;
      ldpc_pkg::TX_SEND: tx_code = ldpc_pkg::TXC_SEND;
      ldpc_pkg::TX_WB: tx_code = ldpc_pkg::TXC_WB;
      ldpc_pkg::TX_SUSP: tx_code = ldpc_pkg::TXC_SUSP;
      default: tx_code = ldpc_pkg::TXC_STOP;
    endcase
  end

  always_comb begin
    tx_cmd.fetch = tx_q == ldpc_pkg::TX_FETCH;
    tx_cmd.fill = tx_q == ldpc_pkg::TX_FILL;
    tx_cmd.send = tx_q == ldpc_pkg::TX_SEND;
    tx_cmd.wb = tx_q == ldpc_pkg::TX_WB;
    tx_cmd.wb_underflow = uf_q;
    tx_cmd.wb_jabber = jab_q;
    tx_cmd.start_level = start_level(nac_q[ldpc_pkg::NAC_LEVEL_LO +: 2], speed_100);
    tx_cmd.force_coll = nac_q[ldpc_pkg::NAC_COLL];
    tx_cmd.loop_mode = nac_q[ldpc_pkg::NAC_LOOP_LO +: 2];
    tx_cmd.backoff_hold = nac_q[ldpc_pkg::NAC_BACKOFF];
    tx_cmd.sqe_off = nac_q[ldpc_pkg::NAC_SQE_OFF];
    tx_cmd.ring_base = {tx_base_q, ldpc_pkg::RING_ALIGN};
  end

  // ****************************************
  // receive process and address filter
  // ****************************************
  assign addr_ok = rx_evt.dest_match | nac_q[ldpc_pkg::NAC_ANY_GOOD]
                   | (rx_evt.multicast & nac_q[ldpc_pkg::NAC_ALL_GROUP]);
  assign frame_ok = addr_ok & (~rx_evt.bad | nac_q[ldpc_pkg::NAC_DAMAGED]);

  always_comb begin
    rx_d = rx_q;
    rci_set = 1'b0;
    rdu_set = 1'b0;
    if (halt_q || any_fault) begin
      rx_d = ldpc_pkg::RX_STOP;
    end else begin
      unique case (rx_q)
        ldpc_pkg::RX_STOP: if (rx_run) rx_d = ldpc_pkg::RX_FETCH;
        ldpc_pkg::RX_FETCH: if (rx_evt.desc_done) begin
          if (!rx_run) begin
            rx_d = ldpc_pkg::RX_STOP;
          end else if (rx_evt.desc_owned) begin
            rx_d = ldpc_pkg::RX_WAIT;
          end else begin
            rx_d = ldpc_pkg::RX_SUSP;
            rdu_set = 1'b1;
          end
        end
        ldpc_pkg::RX_WAIT: begin
          if (!rx_run) begin
            rx_d = ldpc_pkg::RX_STOP;
          end else if (rx_evt.frame_start && addr_ok) begin
            rx_d = ldpc_pkg::RX_DRAIN;
          end
        end
        ldpc_pkg::RX_DRAIN: if (rx_evt.frame_end) begin
          rx_d = frame_ok ? ldpc_pkg::RX_CHECK : ldpc_pkg::RX_FLUSH;
        end
        ldpc_pkg::RX_CHECK: if (rx_evt.desc_done) rx_d = ldpc_pkg::RX_WB;
        ldpc_pkg::RX_WB: if (rx_evt.wr_done) begin
          rci_set = 1'b1;
          rx_d = rx_run ? ldpc_pkg::RX_FETCH : ldpc_pkg::RX_STOP;
        end
        ldpc_pkg::RX_FLUSH: if (rx_evt.flush_done) begin
          rx_d = rx_run ? ldpc_pkg::RX_WAIT : ldpc_pkg::RX_STOP;
        end
        ldpc_pkg::RX_SUSP: begin
          if (!rx_run) begin
            rx_d = ldpc_pkg::RX_STOP;
          end else if (rx_poll || (rx_evt.frame_start && addr_ok)) begin
            rx_d = ldpc_pkg::RX_FETCH;
          end
        end
        default: rx_d = ldpc_pkg::RX_STOP;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_q <= ldpc_pkg::RX_STOP;
    end else begin
      rx_q <= rx_d;
    end
  end

  always_comb begin
    unique case (rx_q)
      ldpc_pkg::RX_STOP: rx_code = ldpc_pkg::RXC_STOP;
      ldpc_pkg::RX_FETCH: rx_code = ldpc_pkg::RXC_FETCH;
      ldpc_pkg::RX_WAIT: rx_code = ldpc_pkg::RXC_WAIT;
      ldpc_pkg::RX_DRAIN: rx_code = ldpc_pkg::RXC_DRAIN;
      ldpc_pkg::RX_CHECK: rx_code = ldpc_pkg::RXC_CHECK;
      ldpc_pkg::RX_WB: rx_code = ldpc_pkg::RXC_WB;
      ldpc_pkg::RX_FLUSH: rx_code = ldpc_pkg::RXC_FLUSH;
      ldpc_pkg::RX_SUSP: rx_code = ldpc_pkg::RXC_SUSP;
      default: rx_code = ldpc_pkg::RXC_STOP;
    endcase
  end

  // control frames set rx_cmd.accept past the address filter and damaged-frame check; the receive states still use addr_ok and frame_ok
  always_comb begin
    rx_cmd.fetch = rx_q == ldpc_pkg::RX_FETCH;
    rx_cmd.drain = rx_q == ldpc_pkg::RX_DRAIN;
    rx_cmd.check = rx_q == ldpc_pkg::RX_CHECK;
    rx_cmd.wb = rx_q == ldpc_pkg::RX_WB;
    rx_cmd.flush = rx_q == ldpc_pkg::RX_FLUSH;
    rx_cmd.accept = frame_ok | rx_evt.ctrl_frame;
    rx_cmd.ring_base = {rx_base_q, ldpc_pkg::RING_ALIGN};
  end

  // ****************************************
  // status flags
  // ****************************************
  always_comb begin
    flag_set = '0;
    flag_set[ldpc_pkg::ST_TX_DONE] = tci_set;
    flag_set[ldpc_pkg::ST_TX_STOP] = tx_d == ldpc_pkg::TX_STOP
                                     && tx_q != ldpc_pkg::TX_STOP;
    flag_set[ldpc_pkg::ST_TX_NODESC] = tdu_set;
    flag_set[ldpc_pkg::ST_JABBER] = tx_q == ldpc_pkg::TX_SEND && tx_evt.jabber;
    flag_set[ldpc_pkg::ST_TX_UNDER] = tx_q == ldpc_pkg::TX_SEND && tx_evt.underflow;
    flag_set[ldpc_pkg::ST_RX_DONE] = rci_set;
    flag_set[ldpc_pkg::ST_RX_NODESC] = rdu_set;
    flag_set[ldpc_pkg::ST_RX_STOP] = rx_d == ldpc_pkg::RX_STOP
                                     && rx_q != ldpc_pkg::RX_STOP;
    flag_set[ldpc_pkg::ST_RX_WDOG] = rx_evt.watchdog;
    flag_set[ldpc_pkg::ST_GP_TIMER] = rx_evt.gp_timer;
    flag_set[ldpc_pkg::ST_FATAL] = any_fault && !halt_q;
  end

  assign clr_word = avs_writedata & be_mask(avs_byteenable);
  assign flag_clr = (wr_fire && avs_address == ldpc_pkg::STATUS_OFS)
                    ? clr_word[ldpc_pkg::ST_FLAGS-1:0]
                    : '0;

  ldpc_sticky #(
    .W(ldpc_pkg::ST_FLAGS)
  ) u_flags (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(flag_set),
    .clr(flag_clr),
    .q(flags)
  );

  assign normal_summary = |(flags & ldpc_pkg::NORMAL_MASK) | sec_normal;
  assign abnormal_summary = |(flags & ldpc_pkg::ABNORMAL_MASK) | sec_abnormal;

endmodule

// >>> tb/ldpc_props.sv
`timescale 1ns/1ps
module ldpc_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire ldpc_pkg::ldpc_tx_evt_type tx_evt,
  input wire ldpc_pkg::ldpc_fault_type fault,
  input wire ldpc_pkg::ldpc_tx_cmd_type tx_cmd,
  input wire ldpc_pkg::ldpc_rx_cmd_type rx_cmd,
  input wire logic bus_master_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  chk_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest || !(avs_read | avs_write))
    else $error("acknowledge held too long");
  chk_fault_halt: assert property (|fault |=> !bus_master_en)
    else $error("mastering not halted after fault");
  chk_halt_kept: assert property (!bus_master_en |=> !bus_master_en)
    else $error("halt released without reset");
  chk_halt_idle: assert property (!bus_master_en |->
    !(tx_cmd.fetch | tx_cmd.fill | rx_cmd.fetch | rx_cmd.drain))
    else $error("engine active while halted");
  chk_under_wb: assert property (tx_cmd.send && tx_evt.underflow && !(|fault) |=>
    tx_cmd.wb && tx_cmd.wb_underflow)
    else $error("underflow not written back");
  chk_jab_wb: assert property (tx_cmd.send && tx_evt.jabber && !(|fault) |=>
    tx_cmd.wb && tx_cmd.wb_jabber)
    else $error("jabber not written back");
  chk_tx_nodesc: assert property (tx_cmd.fetch && tx_evt.desc_done
    && !tx_evt.desc_owned |=> !tx_cmd.fill && !tx_cmd.fetch)
    else $error("unowned descriptor not suspended");
endmodule
bind ldpc_dma_ctrl ldpc_props i_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .tx_evt(tx_evt), .fault(fault),
  .tx_cmd(tx_cmd), .rx_cmd(rx_cmd), .bus_master_en(bus_master_en));

// >>> tb/ldpc_engine_model.sv
`timescale 1ns/1ps
module ldpc_engine_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ldpc_pkg::ldpc_tx_cmd_type tx_cmd,
  input wire ldpc_pkg::ldpc_rx_cmd_type rx_cmd,
  input wire logic tx_own,
  input wire logic rx_own,
  input wire logic [1:0] tx_err,
  input wire logic tx_poll,
  input wire logic rx_go,
  output ldpc_pkg::ldpc_tx_evt_type tx_evt,
  output ldpc_pkg::ldpc_rx_evt_type rx_evt
);
  logic [1:0] gap_q;
  // answers every fourth cycle so a pulse never lands twice in one state
  always_ff @(posedge clk_sys) begin
    gap_q <= sys_rst ? 2'h0 : gap_q + 2'h1;
    tx_evt <= '0;
    rx_evt <= '0;
    tx_evt.poll <= tx_poll;
    tx_evt.fifo_has_frame <= 1'b1;
    tx_evt.fifo_level <= 11'h7ff;
    if (gap_q == 2'h3) begin
      tx_evt.desc_done <= tx_cmd.fetch;
      tx_evt.desc_owned <= tx_own;
      tx_evt.desc_irq <= 1'b1;
      tx_evt.frame_end <= tx_cmd.send && tx_err == 2'h0;
      tx_evt.underflow <= tx_cmd.send && tx_err[0];
      tx_evt.jabber <= tx_cmd.send && tx_err[1];
      tx_evt.wr_done <= tx_cmd.wb;
      rx_evt.desc_done <= rx_cmd.fetch || rx_cmd.check;
      rx_evt.desc_owned <= rx_own;
      rx_evt.frame_start <= rx_go;
      rx_evt.dest_match <= 1'b1;
      rx_evt.frame_end <= rx_cmd.drain;
      rx_evt.wr_done <= rx_cmd.wb;
      rx_evt.flush_done <= rx_cmd.flush;
    end
  end
endmodule

// >>> tb/test_lan_dma_process_control.sv
`timescale 1ns/1ps
module test_lan_dma_process_control;
  logic clk_sys, sys_rst, avs_read, avs_write, speed_100, tx_own, rx_own, tx_poll, rx_go, sec;
  logic avs_waitrequest, bus_master_en;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] tx_err;
  ldpc_pkg::ldpc_tx_evt_type tx_evt;
  ldpc_pkg::ldpc_rx_evt_type rx_evt;
  ldpc_pkg::ldpc_fault_type fault;
  ldpc_pkg::ldpc_tx_cmd_type tx_cmd;
  ldpc_pkg::ldpc_rx_cmd_type rx_cmd;
  int n_mismatch, n_compared;
  localparam logic [7:0] ST = 8'h28;
  localparam logic [7:0] NA = 8'h30;
  localparam logic [10:0] SLOW [4] = '{11'h048, 11'h060, 11'h080, 11'h0a0};
  ldpc_dma_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .speed_100(speed_100), .sec_normal(sec), .sec_abnormal(sec), .tx_evt(tx_evt),
    .rx_evt(rx_evt), .fault(fault), .tx_cmd(tx_cmd), .rx_cmd(rx_cmd),
    .bus_master_en(bus_master_en));
  ldpc_engine_model i_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .tx_cmd(tx_cmd),
    .rx_cmd(rx_cmd), .tx_own(tx_own), .rx_own(rx_own), .tx_err(tx_err), .tx_poll(tx_poll),
    .rx_go(rx_go), .tx_evt(tx_evt), .rx_evt(rx_evt));
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    cmp(rd & m, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulse_poll;
    tx_poll <= 1'b1;
    @(posedge clk_sys);
    tx_poll <= 1'b0;
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdm(8'h10, 32'hffff_ffff, 32'h0fff_ffff);
    rdm(NA, 32'hffff_ffff, 32'h0008_0040);
    rdm(ST, 32'hffff_ffff, 32'h0);
    rdm(8'h04, 32'hffff_ffff, 32'h0);
  endtask
  task automatic t_ring;
    // processes are stopped here, so base writes are allowed
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, i ? 8'h20 : 8'h18, 32'hffff_ffff);
      rdm(i ? 8'h20 : 8'h18, 32'hffff_ffff, 32'hffff_fffc);
      cmp(i ? tx_cmd.ring_base : rx_cmd.ring_base, 32'hffff_fffc);
    end
  endtask
  task automatic t_level;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        speed_100 <= s[0];
        bus(1'b0, NA, {16'h0008, c[1:0], 14'h0040});
        wt(2);
        cmp({21'h0, tx_cmd.start_level}, {21'h0, s ? 11'h080 << c : SLOW[c]});
      end
    end
  endtask
  task automatic t_tx;
    bus(1'b0, NA, 32'h0008_2040);
    wt(20);
    rdm(ST, 32'h0071_0004, 32'h0061_0004);
    tx_own <= 1'b1;
    tx_err <= 2'h1;
    pulse_poll();
    wt(40);
    rdm(ST, 32'h0070_8020, 32'h0060_8020);
    bus(1'b0, ST, 32'h0000_3fff);
    tx_err <= 2'h0;
    pulse_poll();
    wt(40);
    rdm(ST, 32'h0001_8021, 32'h0001_0001);
    tx_err <= 2'h2;
    wt(40);
    rdm(ST, 32'h0000_000a, 32'h0000_000a);
    bus(1'b0, NA, 32'h0008_0040);
    wt(40);
    rdm(ST, 32'h0070_0000, 32'h0);
    tx_err <= 2'h0;
  endtask
  task automatic t_rx;
    bus(1'b0, NA, 32'h0008_0042);
    wt(20);
    rdm(ST, 32'h000e_0080, 32'h0008_0080);
    rx_own <= 1'b1;
    bus(1'b0, 8'h10, 32'h0);
    rx_go <= 1'b1;
    wt(60);
    rdm(ST, 32'h0000_0040, 32'h0000_0040);
    bus(1'b0, NA, 32'h0008_0040);
    wt(60);
    rdm(ST, 32'h000e_0100, 32'h0000_0100);
  endtask
  task automatic t_fault;
    bus(1'b0, NA, 32'h0008_2042);
    wt(10);
    fault <= 3'h2;
    @(posedge clk_sys);
    fault <= 3'h0;
    wt(3);
    rdm(ST, 32'h0380_2000, 32'h0080_2000);
    cmp({31'h0, bus_master_en}, 32'h0);
  endtask
  task automatic t_mode;
    bus(1'b0, NA, 32'h0008_1440);
    wt(1);
    cmp({29'h0, tx_cmd.force_coll, tx_cmd.loop_mode}, 32'h5);
    bus(1'b0, ST, 32'h0000_3fff);
    sec <= 1'b1;
    rdm(ST, 32'h0001_8000, 32'h0001_8000);
    sec <= 1'b0;
    rdm(ST, 32'h0001_ffff, 32'h0);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {avs_read, avs_write, tx_own, rx_own, tx_poll, rx_go, sec} = '0;
    {avs_address, avs_writedata, tx_err, fault} = '0;
    speed_100 = 1'b1;
    sys_rst = 1'b1;
    wt(2);
    sys_rst <= 1'b0;
    t_reset();
    t_ring();
    t_level();
    t_tx();
    t_rx();
    t_fault();
    t_mode();
    wrap_up();
  end
endmodule
